// ==== design/usas_pkg.sv ====
// shared constants and word packing for the usb address-state register
package usas_pkg;

  // register port geometry
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam logic [11:0] ADR_STATE_OFS  = 12'h200;

  // field positions inside the address-state word
  localparam int          STAGE_ERR_BIT  = 15;
  localparam int          EP_BIDIR_BIT   = 14;
  localparam int          SPEED_LSB      = 12;
  localparam int          SUSPEND_BIT    = 11;
  localparam int          STATE_LSB      = 8;
  localparam int          DEV_ADR_LSB    = 0;

  // one-hot device states and speed codes
  localparam logic [2:0]  STATE_DEFAULT    = 3'h1;
  localparam logic [2:0]  STATE_ADDRESSED  = 3'h2;
  localparam logic [2:0]  STATE_CONFIGURED = 3'h4;
  localparam logic [1:0]  SPEED_FULL       = 2'h1;

  // reset values of the whole register word and of the address field
  localparam logic [31:0] ADR_STATE_RESET = 32'h0000_0100;
  localparam logic [6:0]  DEV_ADR_RESET   = 7'h00;

  // assemble one register word; bits 31-16 and 7 read as zero
  function automatic logic [31:0] pack_word(input logic       stage_err,
                                            input logic       bidir,
                                            input logic [1:0] speed,
                                            input logic       susp,
                                            input logic [2:0] state,
                                            input logic [6:0] adr);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[STAGE_ERR_BIT]                = stage_err;
    w[EP_BIDIR_BIT]                 = bidir;
    w[SPEED_LSB+1:SPEED_LSB]        = speed;
    w[SUSPEND_BIT]                  = susp;
    w[STATE_LSB+2:STATE_LSB]        = state;
    w[DEV_ADR_LSB+6:DEV_ADR_LSB]    = adr;
    return w;
  endfunction

endpackage

// ==== design/usas_if.sv ====
// register port joining the software-side controller and the device logic
`timescale 1ns/1ns
interface usas_if;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;

  // device end answers reads
  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  // controller end issues requests
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// ==== design/usas_device.sv ====
// address-state register of the usb device core, device end
`timescale 1ns/1ns
module usas_device (
  // clock, reset and enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // register port
  usas_if.dev              bus,
  // events from the usb protocol engine
  input  wire logic        setup_in_stage,
  input  wire logic        stall_sent,
  input  wire logic        ctrl_done_ok,
  input  wire logic        usb_bus_reset,
  // line status from the usb protocol engine
  input  wire logic        suspended,
  input  wire logic [1:0]  line_speed,
  // register contents toward the core
  output logic             stage_error,
  output logic             ep_bidir,
  output logic [2:0]       dev_state,
  output logic [6:0]       dev_address,
  output logic             suspend_status,
  output logic [1:0]       speed_status
);

  // decode of the register port; only one word is mapped,
  // every other offset is ignored on write and reads as zero
  wire        hit;
  wire        sw_wr;
  wire        sw_rd;
  wire        any_rd;
  wire [31:0] word;

  assign hit    = (bus.addr == usas_pkg::ADR_STATE_OFS);
  assign sw_wr  = bus.wr & hit;
  assign sw_rd  = bus.rd & hit;
  assign any_rd = bus.rd;

  // current image of the register as software sees it;
  // the read-only bits are live copies, not stored writes
  assign word = usas_pkg::pack_word(stage_error,
                                    ep_bidir,
                                    speed_status,
                                    suspend_status,
                                    dev_state,
                                    dev_address);

  // fields of the write word, picked apart once;
  // bits 13 to 11 of a write are read-only and never looked at
  wire       wr_stage_err;
  wire       wr_bidir;
  wire [2:0] wr_state;
  wire [6:0] wr_address;

  assign wr_stage_err = bus.wdata[usas_pkg::STAGE_ERR_BIT];
  assign wr_bidir     = bus.wdata[usas_pkg::EP_BIDIR_BIT];
  assign wr_state     = bus.wdata[usas_pkg::STATE_LSB+2:usas_pkg::STATE_LSB];
  assign wr_address   = bus.wdata[usas_pkg::DEV_ADR_LSB+6:usas_pkg::DEV_ADR_LSB];

  // reset image split into fields; a bus reset loads these through
  // the synchronous path, while the async branch keeps plain constants
  wire       rst_stage_err;
  wire       rst_bidir;
  wire [6:0] rst_address;

  assign rst_stage_err = usas_pkg::ADR_STATE_RESET[usas_pkg::STAGE_ERR_BIT];
  assign rst_bidir     = usas_pkg::ADR_STATE_RESET[usas_pkg::EP_BIDIR_BIT];
  assign rst_address   = usas_pkg::DEV_ADR_RESET;

  // stage error flag: hardware set beats the clean-finish and software clears, so a stall
  // that lands on a clean finish still leaves the flag raised
  wire err_set;
  wire err_clr_hw;
  wire err_clr_sw;
  wire err_clr;
  wire next_stage_error;

  assign err_set    = setup_in_stage | stall_sent;
  assign err_clr_hw = ctrl_done_ok;
  // software may only clear the flag; a written one leaves it alone
  assign err_clr_sw = sw_wr & ~wr_stage_err;
  assign err_clr    = err_clr_hw | err_clr_sw;
  assign next_stage_error = err_set ? 1'b1 :
                            err_clr ? 1'b0 :
                            stage_error;

  // writable fields after a software write; a write to any
  // other offset leaves all of them alone
  wire       next_bidir;
  wire [2:0] next_state;
  wire [6:0] next_address;

  assign next_bidir   = sw_wr ? wr_bidir : ep_bidir;
  // state bits taken as written; keeping them one-hot is up to software
  assign next_state   = sw_wr ? wr_state : dev_state;
  assign next_address = sw_wr ? wr_address : dev_address;

  // stage error register; bus reset returns it to zero
  // ahead of any event in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_error <= usas_pkg::ADR_STATE_RESET[usas_pkg::STAGE_ERR_BIT];
    end else if (ce) begin
      if (usb_bus_reset) begin
        stage_error <= rst_stage_err;
      end else begin
        stage_error <= next_stage_error;
      end
    end
  end

  // endpoint direction select; while set, one endpoint
  // number serves both directions
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ep_bidir <= usas_pkg::ADR_STATE_RESET[usas_pkg::EP_BIDIR_BIT];
    end else if (ce) begin
      if (usb_bus_reset) begin
        ep_bidir <= rst_bidir;
      end else begin
        ep_bidir <= next_bidir;
      end
    end
  end

  // device state: bus reset beats a software write in the same cycle,
  // so a late write cannot leave addressed or configured behind;
  // all three bits load together, never two hot bits in passing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_state <= usas_pkg::STATE_DEFAULT;
    end else if (ce) begin
      if (usb_bus_reset) begin
        dev_state <= usas_pkg::STATE_DEFAULT;
      end else begin
        dev_state <= next_state;
      end
    end
  end

  // assigned bus address; a bus reset drops back to address zero,
  // software writes it only once the set_address status stage is done
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_address <= usas_pkg::DEV_ADR_RESET;
    end else if (ce) begin
      if (usb_bus_reset) begin
        dev_address <= rst_address;
      end else begin
        dev_address <= next_address;
      end
    end
  end

  // suspend copy; read-only, software writes never reach it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      suspend_status <= usas_pkg::ADR_STATE_RESET[usas_pkg::SUSPEND_BIT];
    end else if (ce) begin
      suspend_status <= suspended;
    end
  end

  // speed copy; taken straight from the line, so a reserved code
  // from the protocol engine is shown as it is rather than masked
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_status <= usas_pkg::ADR_STATE_RESET[usas_pkg::SPEED_LSB+1:usas_pkg::SPEED_LSB];
    end else if (ce) begin
      speed_status <= line_speed;
    end
  end

  // read data stands only in the cycle after the strobe;
  // an unmapped read answers zero rather than stale data;
  // reads leave every field untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus.rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (sw_rd) begin
        bus.rdata <= word;
      end else if (any_rd) begin
        bus.rdata <= 32'h0000_0000;
      end else begin
        bus.rdata <= 32'h0000_0000;
      end
    end
  end

endmodule // usas_device

// ==== design/usas_host.sv ====
// software-side controller that steers the address-state register
`timescale 1ns/1ns
module usas_host (
  // clock, reset and enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // register port
  usas_if.host             bus,
  // decoded standard requests from the control pipe
  input  wire logic        req_set_address,
  input  wire logic [6:0]  req_address,
  input  wire logic        req_set_config,
  input  wire logic [7:0]  req_config,
  input  wire logic        status_ok,
  input  wire logic        bus_reset_seen,
  input  wire logic        bidir_mode,
  // register read service
  input  wire logic        rd_req,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  // shadow of what was last written
  output logic [2:0]       shadow_state,
  output logic [6:0]       shadow_address
);

  typedef enum logic [1:0] {USAS_IDLE, USAS_WRITE, USAS_READ} usas_op_e;

  // pending set_address waits for its status stage
  logic       adr_pend;
  logic [6:0] adr_val;
  logic       bidir_last;
  logic       rd_pend;
  logic       rd_q;

  logic       upd;
  logic [2:0] next_state;
  logic [6:0] next_address;
  usas_op_e   op;

  // decide the state and address that the next write carries
  always_comb begin
    upd          = 1'b0;
    next_state   = shadow_state;
    next_address = shadow_address;
    if (status_ok && adr_pend) begin
      upd          = 1'b1;
      next_address = adr_val;
      if (adr_val == 7'h00 && shadow_state != usas_pkg::STATE_CONFIGURED) begin
        next_state = usas_pkg::STATE_DEFAULT;
      end else if (adr_val != 7'h00 && shadow_state == usas_pkg::STATE_DEFAULT) begin
        next_state = usas_pkg::STATE_ADDRESSED;
      end
    end else if (req_set_config) begin
      if (req_config != 8'h00) begin
        upd        = 1'b1;
        next_state = usas_pkg::STATE_CONFIGURED;
      end else if (shadow_state != usas_pkg::STATE_DEFAULT) begin
        upd        = 1'b1;
        next_state = usas_pkg::STATE_ADDRESSED;
      end
    end else if (bidir_mode != bidir_last) begin
      upd = 1'b1;
    end
    // a bus reset is handled by the device itself
    if (bus_reset_seen) begin
      upd = 1'b0;
    end
    op = upd ? USAS_WRITE : ((rd_req || rd_pend) ? USAS_READ : USAS_IDLE);
  end

  // shadow state and pending request tracking
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shadow_state   <= usas_pkg::STATE_DEFAULT;
      shadow_address <= usas_pkg::DEV_ADR_RESET;
      adr_pend       <= 1'b0;
      adr_val        <= usas_pkg::DEV_ADR_RESET;
      bidir_last     <= 1'b0;
    end else if (ce) begin
      if (bus_reset_seen) begin
        shadow_state   <= usas_pkg::STATE_DEFAULT;
        shadow_address <= usas_pkg::DEV_ADR_RESET;
        adr_pend       <= 1'b0;
        bidir_last     <= 1'b0;
      end else begin
        shadow_state   <= next_state;
        shadow_address <= next_address;
        if (upd) begin
          bidir_last <= bidir_mode;
        end
        if (status_ok && adr_pend) begin
          adr_pend <= 1'b0;
        end else if (req_set_address) begin
          adr_pend <= 1'b1;
          adr_val  <= req_address;
        end
      end
    end
  end

  // bus strobes: one cycle each, write wins and a read waits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus.addr  <= 12'h000;
      bus.wdata <= 32'h0000_0000;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      rd_pend   <= 1'b0;
      rd_q      <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 32'h0000_0000;
    end else if (ce) begin
      bus.wr   <= (op == USAS_WRITE);
      bus.rd   <= (op == USAS_READ);
      rd_q     <= bus.rd; // rdata stands the cycle after the strobe
      rd_pend  <= (op == USAS_WRITE) && (rd_req || rd_pend);
      rd_valid <= rd_q;
      if (rd_q) begin
        rd_data <= bus.rdata;
      end
      if (op != USAS_IDLE) begin
        bus.addr <= usas_pkg::ADR_STATE_OFS;
      end
      // full word write; stage error bit written as one to leave it alone
      if (op == USAS_WRITE) begin
        bus.wdata <= usas_pkg::pack_word(1'b1, bidir_mode, 2'h0, 1'b0,
                                         next_state, next_address);
      end
    end
  end

endmodule // usas_host

// ==== verification/usas_asserts.sv ====
// concurrent checks on the address-state register port and fields
`timescale 1ns/1ns
module usas_asserts (
  // clock, reset and enable
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  // register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // device events and fields
  input wire logic        setup_in_stage,
  input wire logic        stall_sent,
  input wire logic        ctrl_done_ok,
  input wire logic        usb_bus_reset,
  input wire logic        stage_error,
  input wire logic        ep_bidir,
  input wire logic [2:0]  dev_state,
  input wire logic [6:0]  dev_address,
  // controller requests
  input wire logic        req_set_config,
  input wire logic [7:0]  req_config,
  input wire logic        status_ok,
  input wire logic        bus_reset_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // only one offset is mapped
  wire sel = addr == usas_pkg::ADR_STATE_OFS;

  property p_err_set;
    ce && !usb_bus_reset && (setup_in_stage || stall_sent) |=> stage_error;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("stage error not set");
  property p_err_clr;
    ce && !usb_bus_reset && ctrl_done_ok && !setup_in_stage && !stall_sent |=> !stage_error;
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("stage error not cleared");
  property p_bus_rst;
    ce && usb_bus_reset |=> dev_state == usas_pkg::STATE_DEFAULT && dev_address == 7'h00
      && !stage_error && !ep_bidir;
  endproperty
  a_bus_rst: assert property (p_bus_rst)
    else $error("bus reset left fields set");
  property p_onehot;
    $onehot(dev_state);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("device state not one-hot");
  property p_rd_fields;
    ce && rd && sel && !usb_bus_reset |=> rdata[31:16] == 16'h0000
      && rdata[10:0] == {$past(dev_state), 1'b0, $past(dev_address)};
  endproperty
  a_rd_fields: assert property (p_rd_fields)
    else $error("read word fields wrong");
  property p_rdata_idle;
    ce && !(rd && sel) |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_wr_fields;
    ce && !usb_bus_reset && wr && sel |=> ep_bidir == $past(wdata[14])
      && dev_address == $past(wdata[6:0]);
  endproperty
  a_wr_fields: assert property (p_wr_fields)
    else $error("write not taken");
  property p_cfg;
    ce && req_set_config && req_config != 8'h00 && !status_ok && !bus_reset_seen
      |=> wr && sel && wdata[10:8] == usas_pkg::STATE_CONFIGURED;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("configured state not written");
endmodule // usas_asserts

// ==== verification/tb_usb_device_address_state.sv ====
// self-checking bench joining the controller end and the device end
`timescale 1ns/1ns
module tb_usb_device_address_state;
  localparam logic [11:0] OFS = usas_pkg::ADR_STATE_OFS;
  logic        clk, resetn, ce, suspended, bidir_mode, stage_error, ep_bidir, rd_valid;
  logic [7:0]  ev;     // event pulses, one bit each
  logic [7:0]  req_config;
  logic [6:0]  req_address, dev_address, shadow_address;
  logic [1:0]  line_speed;
  logic [2:0]  dev_state, shadow_state;
  logic [31:0] rd_data;
  int          errors, comparisons;
  usas_if bi();
  usas_if bx();  // second port driven by the bench itself

  usas_device u_usas_device (.clk(clk), .resetn(resetn), .ce(ce), .bus(bi.dev),
    .setup_in_stage(ev[0]), .stall_sent(ev[1]), .ctrl_done_ok(ev[2]), .usb_bus_reset(ev[3]),
    .suspended(suspended), .line_speed(line_speed), .stage_error(stage_error),
    .ep_bidir(ep_bidir), .dev_state(dev_state), .dev_address(dev_address),
    .suspend_status(), .speed_status());
  usas_device u_usas_device_b (.clk(clk), .resetn(resetn), .ce(ce), .bus(bx.dev),
    .setup_in_stage(ev[0]), .stall_sent(ev[1]), .ctrl_done_ok(ev[2]), .usb_bus_reset(ev[3]),
    .suspended(suspended), .line_speed(line_speed), .stage_error(), .ep_bidir(),
    .dev_state(), .dev_address(), .suspend_status(), .speed_status());
  usas_host u_usas_host (.clk(clk), .resetn(resetn), .ce(ce), .bus(bi.host),
    .req_set_address(ev[4]), .req_address(req_address), .req_set_config(ev[5]),
    .req_config(req_config), .status_ok(ev[6]), .bus_reset_seen(ev[3]),
    .bidir_mode(bidir_mode), .rd_req(ev[7]), .rd_valid(rd_valid), .rd_data(rd_data),
    .shadow_state(shadow_state), .shadow_address(shadow_address));
  usas_asserts u_usas_asserts (.clk(clk), .resetn(resetn), .ce(ce), .addr(bi.addr),
    .wdata(bi.wdata), .wr(bi.wr), .rd(bi.rd), .rdata(bi.rdata), .setup_in_stage(ev[0]),
    .stall_sent(ev[1]), .ctrl_done_ok(ev[2]), .usb_bus_reset(ev[3]),
    .stage_error(stage_error), .ep_bidir(ep_bidir), .dev_state(dev_state),
    .dev_address(dev_address), .req_set_config(ev[5]), .req_config(req_config),
    .status_ok(ev[6]), .bus_reset_seen(ev[3]));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle event, request data launched with it
  task automatic pulse(input int i, input logic [7:0] v = 8'h00);
    @(posedge clk);
    ev[i] <= 1'b1;
    req_address <= v[6:0];
    req_config <= v;
    @(posedge clk) ev <= 8'h00;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // read through the controller, bounded wait for its valid pulse
  task automatic hread(input string nm, input logic [31:0] exp);
    pulse(7);
    repeat (8) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) break;
    end
    chk({nm, " valid"}, {31'h0, rd_valid}, 32'h1);
    chk(nm, rd_data, exp);
  endtask
  task automatic bwr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bx.addr <= a;
    bx.wdata <= d;
    bx.wr <= 1'b1;
    @(posedge clk) bx.wr <= 1'b0;
  endtask
  // read data must stand for exactly one cycle
  task automatic brd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    bx.addr <= a;
    bx.rd <= 1'b1;
    @(posedge clk) bx.rd <= 1'b0;
    #1 chk(nm, bx.rdata, exp);
    @(posedge clk) #1 chk({nm, " idle"}, bx.rdata, 32'h0);
  endtask
  task automatic chk_st(input string nm, input logic [2:0] st, input logic [6:0] ad);
    chk(nm, {22'h0, dev_state, dev_address}, {22'h0, st, ad});
    chk({nm, " shadow"}, {22'h0, shadow_state, shadow_address}, {22'h0, st, ad});
  endtask

  task automatic t_states();
    pulse(4, 8'h05);
    pulse(6);
    settle();
    chk_st("set address", usas_pkg::STATE_ADDRESSED, 7'h05);
    pulse(5, 8'h03);
    settle();
    chk_st("set config", usas_pkg::STATE_CONFIGURED, 7'h05);
    hread("config word", 32'h0000_1405);
    pulse(5, 8'h00);
    settle();
    chk_st("config zero", usas_pkg::STATE_ADDRESSED, 7'h05);
    pulse(4, 8'h00);
    pulse(6);
    settle();
    chk_st("address zero", usas_pkg::STATE_DEFAULT, 7'h00);
    $display("test states done");
  endtask
  task automatic t_stage();
    pulse(0);
    #1 chk("setup error", {31'h0, stage_error}, 32'h1);
    pulse(2);
    #1 chk("clean clear", {31'h0, stage_error}, 32'h0);
    pulse(1);
    #1 chk("stall error", {31'h0, stage_error}, 32'h1);
    @(posedge clk) bidir_mode <= 1'b1;
    settle();
    hread("bidir word", 32'h0000_d100);
    pulse(3);
    #1 chk("bus rst", {20'h0, ep_bidir, stage_error, dev_state, dev_address}, 32'h080);
    $display("test stage done");
  endtask
  task automatic t_direct();
    brd("b reset", OFS, 32'h0000_1100);
    bwr(OFS, 32'hffff_3a7f);
    brd("b read-only", OFS, 32'h0000_127f);
    bwr(12'h204, 32'h0000_4101);
    brd("b unmapped", 12'h204, 32'h0);
    brd("b kept", OFS, 32'h0000_127f);
    @(posedge clk) suspended <= 1'b1;
    pulse(1);
    brd("b suspend", OFS, 32'h0000_9a7f);
    bwr(OFS, 32'h0000_027f);
    brd("b sw clear", OFS, 32'h0000_1a7f);
    // stall and clean finish in one cycle: the set must win
    @(posedge clk) ev <= 8'h06;
    @(posedge clk) ev <= 8'h00;
    brd("b set wins", OFS, 32'h0000_9a7f);
    $display("test direct done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    suspended = 1'b0;
    bidir_mode = 1'b0;
    ev = 8'h00;
    req_address = 7'h00;
    req_config = 8'h00;
    line_speed = usas_pkg::SPEED_FULL;
    bx.addr = 12'h000;
    bx.wdata = 32'h0;
    bx.wr = 1'b0;
    bx.rd = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    hread("reset word", 32'h0000_1100);
    t_states();
    t_stage();
    t_direct();
    tally_and_finish();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule // tb_usb_device_address_state
